// [core/clm_host.sv]
// Baseband end: clock sources, serial master and APB register slave
//
// Decided for this implementation: the APB interface to the registers and the address map.
`include "clm_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module clm_host
   import clm_pkg::*;
#(
   parameter logic [7:0] LINK_HALF = 8'(`CLM_LINK_HALF),
   parameter logic [7:0] SCLK_HALF = 8'(`CLM_SCLK_HALF)
) (
   // Clock, reset, enable
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        ce,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // Interrupt
   output logic             irq,
   // Link to the converter
   clm_if.host              link
);
   clm_host_reg_t q;
   clm_host_reg_t next_q;

   logic [1:0]  hs;
   logic        sdi;
   logic        start;
   logic        done;
   logic [1:0]  clr;
   logic [1:0]  ev;

   // Pins from the converter side
   clm_sync #(
      .W    (2),
      .INIT (2'h0)
   ) u_sync (
      .clk (clk),
      .rst (rst),
      .ce  (ce),
      .d   ({link.alarm_or_readback_pin, link.sdio_level}),
      .q   (hs)
   );

   // (R14) Read data from the alarm pin in four-pin mode
   assign sdi = q.ctrl[`CLM_CTRL_FOUR] ? hs[`CLM_HY_ALARM] : hs[`CLM_HY_SDIO];

   ////////////////////////////////////////////////////////////////////////////////
   // Next state
   always_comb begin
      next_q = q;
      start  = 1'h0;
      done   = 1'h0;
      clr    = '0;
      ev     = '0;

      // (R11) Data and converter clocks from one divider
      if (q.ldiv == LINK_HALF - 8'h01) begin
         next_q.ldiv = '0;
         next_q.dclk = q.ctrl[`CLM_CTRL_DCLK] & ~q.dclk;
         next_q.cclk = q.ctrl[`CLM_CTRL_CCLK] & ~q.cclk;
      end else begin
         next_q.ldiv = q.ldiv + 8'h01;
      end

      // APB: answer one cycle into the access phase, act on the closing edge
      next_q.pready  = 1'h0;
      next_q.pslverr = 1'h0;
      if (psel && penable && !q.pready) begin
         next_q.pready = 1'h1;
         next_q.prdata = '0;
         case (paddr)
            `CLM_APB_CTRL:     next_q.prdata[2:0] = q.ctrl;
            `CLM_APB_CMD:      next_q.prdata = '0;
            `CLM_APB_STATUS:   next_q.prdata = {16'h0000, q.rdata, 6'h00, hs[`CLM_HY_ALARM], q.state != CLM_IDLE};
            `CLM_APB_IRQ_STAT: next_q.prdata[1:0] = q.irq_stat;
            `CLM_APB_IRQ_MASK: next_q.prdata[1:0] = q.irq_mask;
            default:           next_q.pslverr = 1'h1;
         endcase
      end else if (psel && penable && pwrite) begin
         case (paddr)
            `CLM_APB_CTRL:     next_q.ctrl = pwdata[2:0];
            `CLM_APB_CMD:      start = (q.state == CLM_IDLE);
            `CLM_APB_IRQ_STAT: clr = pwdata[1:0];
            `CLM_APB_IRQ_MASK: next_q.irq_mask = pwdata[1:0];
            default:           ;
         endcase
      end

      // Serial master
      unique case (q.state)
         CLM_IDLE: begin
            if (start) begin
               next_q.frame   = pwdata[15:0];
               next_q.rd      = pwdata[`CLM_RW_BIT];
               next_q.sdo     = pwdata[`CLM_RW_BIT];
               next_q.soe     = 1'h1;
               next_q.sen_n   = 1'h0;
               next_q.bit_cnt = '0;
               next_q.sdiv    = '0;
               next_q.rdata   = '0;
               next_q.state   = CLM_SHIFT;
            end
         end
         CLM_SHIFT: begin
            if (q.sdiv == SCLK_HALF - 8'h01) begin
               next_q.sdiv = '0;
               if (!q.sclk) begin
                  next_q.sclk = 1'h1;
                  if (q.rd && (q.bit_cnt > `CLM_CMD_LAST)) begin
                     next_q.rdata = {q.rdata[6:0], sdi};
                  end
               end else begin
                  next_q.sclk    = 1'h0;
                  next_q.bit_cnt = q.bit_cnt + 5'h01;
                  if (q.bit_cnt == `CLM_DATA_LAST) begin
                     next_q.sen_n = 1'h1;
                     next_q.soe   = 1'h0;
                     next_q.state = CLM_GAP;
                     done         = 1'h1;
                  end else begin
                     next_q.frame = {q.frame[14:0], 1'h0};
                     next_q.sdo   = q.frame[14];
                     if (q.rd && (q.bit_cnt == `CLM_CMD_LAST)) begin
                        next_q.soe = 1'h0;
                     end
                  end
               end
            end else begin
               next_q.sdiv = q.sdiv + 8'h01;
            end
         end
         CLM_GAP: begin
            if (q.sdiv == SCLK_HALF - 8'h01) begin
               next_q.state = CLM_IDLE;
            end else begin
               next_q.sdiv = q.sdiv + 8'h01;
            end
         end
         default: begin
            next_q.state = CLM_IDLE;
         end
      endcase

      // Sticky events; a set in the clearing cycle wins
      next_q.alarm_d          = hs[`CLM_HY_ALARM];
      ev[`CLM_IRQ_DONE]       = done;
      ev[`CLM_IRQ_ALARM]      = ~q.ctrl[`CLM_CTRL_FOUR] & hs[`CLM_HY_ALARM] & ~q.alarm_d;
      next_q.irq_stat         = (q.irq_stat & ~clr) | ev;
      next_q.irq              = |(next_q.irq_stat & next_q.irq_mask);
   end

   ////////////////////////////////////////////////////////////////////////////////
   // State register
   always_ff @(posedge clk) begin
      if (rst) begin
         q       <= '0;
         q.sen_n <= 1'h1;
      end else if (ce) begin
         q <= next_q;
      end
   end

   // Outputs straight from flip-flops
   assign prdata                = q.prdata;
   assign pready                = q.pready;
   assign pslverr               = q.pslverr;
   assign irq                   = q.irq;
   assign link.input_data_clock = q.dclk;
   assign link.converter_clock  = q.cclk;
   assign link.serial_enable_n  = q.sen_n;
   assign link.serial_clock     = q.sclk;
   assign link.host_sdio_out    = q.sdo;
   assign link.host_sdio_oe     = q.soe;
endmodule : clm_host

`default_nettype wire

// [core/clm_cfg.svh]
// Constants for the input clock loss monitor and its controller
`ifndef CLM_CFG_SVH
`define CLM_CFG_SVH

// Clock rates and link timing
`define CLM_CLK_NS       50
`define CLM_LINK_NS      400
`define CLM_SCLK_NS      800
`define CLM_LINK_HALF    (`CLM_LINK_NS / (2 * `CLM_CLK_NS))
`define CLM_SCLK_HALF    (`CLM_SCLK_NS / (2 * `CLM_CLK_NS))

// Serial frame: read flag, 7-bit address, 8-bit data, MSB first
`define CLM_FRAME_BITS   16
`define CLM_RW_BIT       15
`define CLM_ADDR_HI      14
`define CLM_ADDR_LO      8
`define CLM_CMD_RW       7
`define CLM_CMD_LAST     5'h07
`define CLM_DATA_LAST    5'h0f
`define CLM_FRAME_END    5'h10

// Device register addresses and fields
`define CLM_ADDR_CONTROL 7'h11
`define CLM_ADDR_ALARMS  7'h1f
`define CLM_CTL_KILL_ARM 0
`define CLM_CTL_LOSS_ARM 1
`define CLM_CTL_KILL_MSK 3
`define CLM_CTL_LOSS_MSK 4
`define CLM_ALM_KILL     6
`define CLM_ALM_LOSS     7
`define CLM_CTL_RESET    8'h00
`define CLM_LOSS_LIMIT   3'h4
`define CLM_SAMPLE_W     16
`define CLM_MID_SCALE    16'h8000

// Device synchroniser lanes
`define CLM_SY_DCLK      0
`define CLM_SY_CCLK      1
`define CLM_SY_SEN       2
`define CLM_SY_SCLK      3
`define CLM_SY_SDIO      4
`define CLM_SY_FOUR      5
`define CLM_SY_INIT      6'h04

// Controller APB map and fields
`define CLM_APB_CTRL     8'h00
`define CLM_APB_CMD      8'h04
`define CLM_APB_STATUS   8'h08
`define CLM_APB_IRQ_STAT 8'h0c
`define CLM_APB_IRQ_MASK 8'h10
`define CLM_CTRL_DCLK    0
`define CLM_CTRL_CCLK    1
`define CLM_CTRL_FOUR    2
`define CLM_ST_BUSY      0
`define CLM_ST_ALARM     1
`define CLM_IRQ_DONE     0
`define CLM_IRQ_ALARM    1
`define CLM_HY_ALARM     1
`define CLM_HY_SDIO      0

`endif

// [core/clm_pkg.sv]
// Types shared by both ends of the clock loss monitor link
package clm_pkg;

   // Serial master sequencing
   typedef enum logic [1:0] {
      CLM_IDLE  = 2'b00,
      CLM_SHIFT = 2'b01,
      CLM_GAP   = 2'b10
   } clm_host_state_t;

   // Device end state
   typedef struct packed {
      logic [7:0]  clock_monitor_control;
      logic        loss_latch;
      logic        kill_latch;
      logic [2:0]  count;
      logic        dclk_d;
      logic        cclk_d;
      logic        sclk_d;
      logic [15:0] sh;
      logic [4:0]  bit_cnt;
      logic        rd_active;
      logic [7:0]  rd_sh;
      logic        sdio_out;
      logic        sdio_oe;
      logic        alarm_pin;
      logic [15:0] sample_out;
   } clm_dev_reg_t;

   // Controller end state
   typedef struct packed {
      clm_host_state_t state;
      logic [2:0]      ctrl;
      logic            rd;
      logic [15:0]     frame;
      logic [7:0]      rdata;
      logic [4:0]      bit_cnt;
      logic [7:0]      sdiv;
      logic [7:0]      ldiv;
      logic            dclk;
      logic            cclk;
      logic            sen_n;
      logic            sclk;
      logic            sdo;
      logic            soe;
      logic [1:0]      irq_stat;
      logic [1:0]      irq_mask;
      logic            alarm_d;
      logic            pready;
      logic            pslverr;
      logic [31:0]     prdata;
      logic            irq;
   } clm_host_reg_t;

endpackage : clm_pkg

// [core/clm_if.sv]
// Link between the baseband controller and the converter clock monitor
`timescale 1ns/1ps
`default_nettype none

interface clm_if;
   logic input_data_clock;
   logic converter_clock;
   logic serial_enable_n;
   logic serial_clock;
   logic host_sdio_out;
   logic host_sdio_oe;
   logic dev_sdio_out;
   logic dev_sdio_oe;
   logic alarm_or_readback_pin;
   logic sdio_level;

   // Shared data line, pulled high when nobody drives
   assign sdio_level = dev_sdio_oe ? dev_sdio_out : (host_sdio_oe ? host_sdio_out : 1'h1);

   modport dev (
      input  input_data_clock, converter_clock, serial_enable_n, serial_clock, sdio_level,
      output dev_sdio_out, dev_sdio_oe, alarm_or_readback_pin
   );
   modport host (
      output input_data_clock, converter_clock, serial_enable_n, serial_clock, host_sdio_out, host_sdio_oe,
      input  sdio_level, alarm_or_readback_pin
   );
endinterface : clm_if

`default_nettype wire

// [core/clm_sync.sv]
// Two-stage synchroniser for pins from outside the clock domain
`timescale 1ns/1ps
`default_nettype none

module clm_sync #(
   parameter int          W    = 1,
   parameter logic [W-1:0] INIT = '0
) (
   // Clock, reset, enable
   input  wire logic         clk,
   input  wire logic         rst,
   input  wire logic         ce,
   // Asynchronous in, synchronous out
   input  wire logic [W-1:0] d,
   output logic [W-1:0]      q
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } clm_sync_reg_t;

   clm_sync_reg_t r;
   clm_sync_reg_t next_r;

   // First stage feeds only the second
   always_comb begin
      next_r    = r;
      next_r.s1 = d;
      next_r.s2 = r.s1;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         r.s1 <= INIT;
         r.s2 <= INIT;
      end else if (ce) begin
         r <= next_r;
      end
   end

   assign q = r.s2;
endmodule : clm_sync

`default_nettype wire

// [core/clm_monitor.sv]
// Converter end: data clock loss monitor with serial register port
`include "clm_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// (R1) Data clock clears counter, FIFO clock increments
// (R2) Count past four sets both latches
// (R3) Loss flag readable at alarms bit 7
// (R4) Kill flag bit 6 forces mid-scale output
// (R5) Loss arm low holds latch; one clears
// (R6) Kill arm low holds latch; one clears
// (R7) Alarm pin driven by both latches, 3-pin
// (R8) Mask bits hide alarms from the pin
// (R9) Writing arm zero forces latch low immediately
// (R10) Host toggles arm zero then one
// (R11) Host configures, clocks, arms, then unmasks
// (R12) Unmasked clock loss changes alarm pin level
// (R13) Host recovers clock, re-arms loss, then kill
// (R14) Four-pin mode: pin returns read data
// (R15) Synchronise clock edges before counter use
module clm_monitor
   import clm_pkg::*;
(
   // Clock, reset, enable
   input  wire logic                     clk,
   input  wire logic                     rst,
   input  wire logic                     ce,
   // Link to the baseband controller
   clm_if.dev                            link,
   // Converter sample path
   input  wire logic [`CLM_SAMPLE_W-1:0] sample_in,
   output logic [`CLM_SAMPLE_W-1:0]      sample_out,
   // Serial port width strap
   input  wire logic                     four_pin_mode
);
   clm_dev_reg_t q;
   clm_dev_reg_t next_q;

   logic [5:0]  s;
   logic        d_rise;
   logic        c_rise;
   logic        s_rise;
   logic        s_fall;
   logic        loss_pulse;
   logic        ctl_wr;
   logic [15:0] frame;
   logic [7:0]  alarms;
   logic [7:0]  rd_word;

   ////////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers
   // (R15) Edges sampled twice
   clm_sync #(
      .W    (6),
      .INIT (`CLM_SY_INIT)
   ) u_sync (
      .clk (clk),
      .rst (rst),
      .ce  (ce),
      .d   ({four_pin_mode, link.sdio_level, link.serial_clock, link.serial_enable_n,
             link.converter_clock, link.input_data_clock}),
      .q   (s)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Edge detection on synchronised pins
   assign d_rise = s[`CLM_SY_DCLK] & ~q.dclk_d;
   assign c_rise = s[`CLM_SY_CCLK] & ~q.cclk_d;
   assign s_rise = s[`CLM_SY_SCLK] & ~q.sclk_d & ~s[`CLM_SY_SEN];
   assign s_fall = ~s[`CLM_SY_SCLK] & q.sclk_d & ~s[`CLM_SY_SEN];

   // (R2) Missing clock pulse
   assign loss_pulse = c_rise & ~d_rise & (q.count >= `CLM_LOSS_LIMIT);

   // Frame as it stands after the current serial bit
   assign frame = {q.sh[`CLM_FRAME_BITS-2:0], s[`CLM_SY_SDIO]};

   // Write to the control register completes on the last bit
   assign ctl_wr = s_rise && (q.bit_cnt == `CLM_DATA_LAST) && !frame[`CLM_RW_BIT]
                   && (frame[`CLM_ADDR_HI:`CLM_ADDR_LO] == `CLM_ADDR_CONTROL);

   // (R3) Read-only alarm flags
   always_comb begin
      alarms                = '0;
      alarms[`CLM_ALM_LOSS] = q.loss_latch;
      alarms[`CLM_ALM_KILL] = q.kill_latch;
   end

   // Read data chosen when the command byte is complete
   always_comb begin
      case (frame[6:0])
         `CLM_ADDR_CONTROL: rd_word = q.clock_monitor_control;
         `CLM_ADDR_ALARMS:  rd_word = alarms;
         default:           rd_word = '0;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Next state
   always_comb begin
      next_q        = q;
      next_q.dclk_d = s[`CLM_SY_DCLK];
      next_q.cclk_d = s[`CLM_SY_CCLK];
      next_q.sclk_d = s[`CLM_SY_SCLK];

      // Control register update
      if (ctl_wr) begin
         next_q.clock_monitor_control = frame[7:0];
      end

      // (R1) Counter cleared by data clock, advanced by FIFO clock
      if (d_rise || (ctl_wr && (frame[`CLM_CTL_LOSS_ARM] || frame[`CLM_CTL_KILL_ARM]))) begin
         next_q.count = '0;
      end else if (c_rise && (q.count != 3'h7)) begin
         next_q.count = q.count + 3'h1;
      end

      // (R5) Loss latch held, set, or cleared by arming
      // (R9) Arm zero drops the latch at once
      if (!next_q.clock_monitor_control[`CLM_CTL_LOSS_ARM]) begin
         next_q.loss_latch = 1'h0;
      end else if (loss_pulse) begin
         next_q.loss_latch = 1'h1;
      end else if (ctl_wr && frame[`CLM_CTL_LOSS_ARM]) begin
         next_q.loss_latch = 1'h0;
      end

      // (R6) Kill latch held, set, or cleared by arming
      // (R9) Arm zero drops the latch at once
      if (!next_q.clock_monitor_control[`CLM_CTL_KILL_ARM]) begin
         next_q.kill_latch = 1'h0;
      end else if (loss_pulse) begin
         next_q.kill_latch = 1'h1;
      end else if (ctl_wr && frame[`CLM_CTL_KILL_ARM]) begin
         next_q.kill_latch = 1'h0;
      end

      // Serial receive and read-back shifting
      if (s[`CLM_SY_SEN]) begin
         next_q.bit_cnt   = '0;
         next_q.rd_active = 1'h0;
         next_q.sdio_oe   = 1'h0;
      end else begin
         if (s_rise) begin
            next_q.sh = frame;
            if (q.bit_cnt != `CLM_FRAME_END) begin
               next_q.bit_cnt = q.bit_cnt + 5'h01;
            end
            if ((q.bit_cnt == `CLM_CMD_LAST) && frame[`CLM_CMD_RW]) begin
               next_q.rd_active = 1'h1;
               next_q.rd_sh     = rd_word;
            end
         end
         if (s_fall && q.rd_active) begin
            if (q.bit_cnt == `CLM_FRAME_END) begin
               next_q.rd_active = 1'h0;
               next_q.sdio_oe   = 1'h0;
            end else begin
               next_q.sdio_out = q.rd_sh[7];
               next_q.rd_sh    = {q.rd_sh[6:0], 1'h0};
               next_q.sdio_oe  = ~s[`CLM_SY_FOUR];
            end
         end
      end

      // (R4) Kill latch forces mid-scale
      next_q.sample_out = next_q.kill_latch ? `CLM_MID_SCALE : sample_in;

      // (R14) Four-pin mode returns read data on the pin
      if (s[`CLM_SY_FOUR]) begin
         next_q.alarm_pin = next_q.sdio_out;
      end else begin
         // (R7) Both latches reach the pin
         // (R8) Mask bits hide each alarm
         // (R12) Pin rises on unmasked loss
         next_q.alarm_pin = (next_q.loss_latch & ~next_q.clock_monitor_control[`CLM_CTL_LOSS_MSK])
                          | (next_q.kill_latch & ~next_q.clock_monitor_control[`CLM_CTL_KILL_MSK]);
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // State register
   always_ff @(posedge clk) begin
      if (rst) begin
         q                       <= '0;
         q.clock_monitor_control <= `CLM_CTL_RESET;
      end else if (ce) begin
         q <= next_q;
      end
   end

   // Outputs straight from flip-flops
   assign sample_out                 = q.sample_out;
   assign link.dev_sdio_out          = q.sdio_out;
   assign link.dev_sdio_oe           = q.sdio_oe;
   assign link.alarm_or_readback_pin = q.alarm_pin;
endmodule : clm_monitor

`default_nettype wire

// [verification/clm_link_assertions.sv]
// Protocol and alarm checks across the clock loss monitor link
`timescale 1ns/1ps
`default_nettype none

module clm_link_assertions #(
   parameter int SCLK_HALF = 8,
   parameter int LINK_HALF = 2
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Link signals
   input wire logic input_data_clock,
   input wire logic converter_clock,
   input wire logic serial_enable_n,
   input wire logic serial_clock,
   input wire logic host_sdio_out,
   input wire logic host_sdio_oe,
   input wire logic dev_sdio_out,
   input wire logic dev_sdio_oe,
   input wire logic alarm_or_readback_pin,
   input wire logic sdio_level
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   // Data clock idle time, frame length, serial rises, converter high time
   logic [7:0] idle_cnt;
   logic [8:0] low_cnt;
   logic [4:0] rise_cnt;
   logic [3:0] hi_cnt;
   logic       dclk_d;
   logic       sclk_d;
   always_ff @(posedge clk) begin
      dclk_d   <= input_data_clock;
      sclk_d   <= serial_clock;
      idle_cnt <= (rst || (input_data_clock && !dclk_d)) ? 8'h00 : idle_cnt + 8'(idle_cnt != 8'hff);
      low_cnt  <= serial_enable_n ? 9'h000 : low_cnt + 9'h001;
      rise_cnt <= serial_enable_n ? 5'h00 : rise_cnt + 5'(serial_clock && !sclk_d);
      hi_cnt   <= converter_clock ? hi_cnt + 4'h1 : 4'h0;
   end

   ////////////////////////////////////////
   a_alarm_on_loss: assert property (
      $rose(alarm_or_readback_pin) |-> idle_cnt >= 8'h10 || !serial_enable_n)
      else $error("alarm pin rose while the data clock was running");
   a_alarm_sticky: assert property (
      $fell(alarm_or_readback_pin) |-> !serial_enable_n || $past(!serial_enable_n))
      else $error("alarm pin dropped without a control write");
   a_sclk_idle: assert property (
      serial_enable_n |-> !serial_clock)
      else $error("serial clock moved outside a frame");
   a_host_bit_hold: assert property (
      host_sdio_oe && $past(host_sdio_oe) && !serial_enable_n && $changed(host_sdio_out) |-> $fell(serial_clock))
      else $error("host data changed away from a serial clock fall");
   a_dev_release: assert property (
      serial_enable_n [*6] |-> !dev_sdio_oe)
      else $error("device still drives data outside a frame");
   a_no_contention: assert property (
      !(dev_sdio_oe && host_sdio_oe))
      else $error("both ends drive the data line");
   a_frame_bits: assert property (
      $rose(serial_enable_n) |-> rise_cnt == 5'h10)
      else $error("frame did not carry sixteen clock rises");
   a_frame_span: assert property (
      $rose(serial_enable_n) |-> int'(low_cnt) >= 31 * SCLK_HALF && int'(low_cnt) <= 33 * SCLK_HALF)
      else $error("frame length off");
   a_cclk_period: assert property (
      $fell(converter_clock) |-> hi_cnt == 4'(LINK_HALF))
      else $error("converter clock high time off");
endmodule : clm_link_assertions

`default_nettype wire

// [verification/input_clock_loss_monitor_tb.sv]
// Self-checking bench: controller and monitor joined across the link
`include "clm_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module input_clock_loss_monitor_tb;
   localparam int LH = 2;
   localparam int SH = 8;
   // Bench-driven inputs
   logic        clk       = 1'b0;
   logic        rst       = 1'b1;
   logic        psel      = 1'b0;
   logic        penable   = 1'b0;
   logic        pwrite    = 1'b0;
   logic [7:0]  paddr     = 8'h00;
   logic [31:0] pwdata    = 32'h0;
   logic [15:0] sample_in = 16'h1234;
   logic        four_pin  = 1'b0;
   // Observed outputs and bookkeeping
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        irq;
   logic [15:0] sample_out;
   logic        pin;
   logic [31:0] rd;
   logic        er;
   int          miscompares = 0;
   int          num_checks  = 0;

   // Half-period clock toggle
   always #25 clk = ~clk;

   // Both ends across one link, checker beside it
   clm_if clm_if_inst ();
   assign pin = clm_if_inst.alarm_or_readback_pin;
   clm_host #(.LINK_HALF(8'(LH)), .SCLK_HALF(8'(SH))) clm_host_inst (
      .clk(clk), .rst(rst), .ce(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .irq(irq), .link(clm_if_inst.host));
   clm_monitor clm_monitor_inst (
      .clk(clk), .rst(rst), .ce(1'b1), .link(clm_if_inst.dev), .sample_in(sample_in),
      .sample_out(sample_out), .four_pin_mode(four_pin));
   clm_link_assertions #(.SCLK_HALF(SH), .LINK_HALF(LH)) clm_link_assertions_inst (
      .clk(clk), .rst(rst), .input_data_clock(clm_if_inst.input_data_clock),
      .converter_clock(clm_if_inst.converter_clock), .serial_enable_n(clm_if_inst.serial_enable_n),
      .serial_clock(clm_if_inst.serial_clock), .host_sdio_out(clm_if_inst.host_sdio_out),
      .host_sdio_oe(clm_if_inst.host_sdio_oe), .dev_sdio_out(clm_if_inst.dev_sdio_out),
      .dev_sdio_oe(clm_if_inst.dev_sdio_oe), .alarm_or_readback_pin(pin), .sdio_level(clm_if_inst.sdio_level));

   ////////////////////////////////////////
   // Compare and count
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk

   // One APB transfer, held until pready is seen at an edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   // Serial frame through the command register, then poll until idle
   task automatic frame(input logic r, input logic [6:0] a, input logic [7:0] d);
      apb(1'b1, `CLM_APB_CMD, {16'h0000, r, a, d});
      do begin
         apb(1'b0, `CLM_APB_STATUS, 32'h0);
      end while (rd[`CLM_ST_BUSY] !== 1'b0);
   endtask : frame

   // Let outputs settle, ending away from the rising edge
   task automatic settle(input int c);
      repeat (c) @(negedge clk);
   endtask : settle

   ////////////////////////////////////////
   // reset values
   task automatic t_reset;
      apb(1'b0, `CLM_APB_CTRL, 32'h0);
      chk("host ctrl", 32'h0, rd);
      frame(1'b1, `CLM_ADDR_CONTROL, 8'h00);
      chk("device control", 32'h0, rd[15:8]);
      chk("alarm pin", 32'h0, pin);
   endtask : t_reset

   task automatic t_setup;
      apb(1'b1, `CLM_APB_CTRL, 32'h3);
      frame(1'b0, `CLM_ADDR_CONTROL, 8'h18);
      frame(1'b0, `CLM_ADDR_CONTROL, 8'h1b);
      frame(1'b0, `CLM_ADDR_CONTROL, 8'h03);
      settle(100);
      frame(1'b1, `CLM_ADDR_CONTROL, 8'h00);
      chk("control readback", 32'h03, rd[15:8]);
      frame(1'b1, `CLM_ADDR_ALARMS, 8'h00);
      chk("alarms idle", 32'h0, rd[15:8]);
      settle(1);
      chk("pin idle", 32'h0, pin);
      chk("sample pass", 32'h1234, sample_out);
      chk("irq idle", 32'h0, irq);
   endtask : t_setup

   task automatic t_loss;
      apb(1'b1, `CLM_APB_IRQ_MASK, 32'h2);
      apb(1'b1, `CLM_APB_CTRL, 32'h2);
      settle(60);
      chk("irq on loss", 32'h1, irq);
      chk("pin on loss", 32'h1, pin);
      chk("mid scale", 32'h8000, sample_out);
      frame(1'b1, `CLM_ADDR_ALARMS, 8'h00);
      chk("alarms set", 32'hc0, rd[15:8]);
      apb(1'b1, `CLM_APB_IRQ_STAT, 32'h3);
      apb(1'b0, `CLM_APB_IRQ_STAT, 32'h0);
      chk("irq stat cleared", 32'h0, rd[1]);
      settle(2);
      chk("irq dropped", 32'h0, irq);
   endtask : t_loss

   // one mask setting and the pin it leaves
   task automatic mask_step(input logic [7:0] v, input logic e);
      frame(1'b0, `CLM_ADDR_CONTROL, v);
      settle(60);
      chk("masked pin", {31'h0, e}, pin);
   endtask : mask_step

   task automatic t_arm;
      frame(1'b0, `CLM_ADDR_CONTROL, 8'h02);
      settle(60);
      chk("kill released", 32'h1234, sample_out);
      frame(1'b1, `CLM_ADDR_ALARMS, 8'h00);
      chk("loss only", 32'h80, rd[15:8]);
      frame(1'b0, `CLM_ADDR_CONTROL, 8'h00);
      settle(1);
      chk("pin disarmed", 32'h0, pin);
      frame(1'b1, `CLM_ADDR_ALARMS, 8'h00);
      chk("alarms held", 32'h0, rd[15:8]);
   endtask : t_arm

   task automatic t_recover;
      apb(1'b1, `CLM_APB_CTRL, 32'h3);
      sample_in <= 16'h5a5a;
      frame(1'b0, `CLM_ADDR_CONTROL, 8'h02);
      settle(100);
      frame(1'b1, `CLM_ADDR_ALARMS, 8'h00);
      chk("loss stays clear", 32'h0, rd[15:8]);
      frame(1'b0, `CLM_ADDR_CONTROL, 8'h03);
      settle(100);
      frame(1'b1, `CLM_ADDR_ALARMS, 8'h00);
      chk("all clear", 32'h0, rd[15:8]);
      chk("real data", 32'h5a5a, sample_out);
      chk("pin clear", 32'h0, pin);
   endtask : t_recover

   task automatic t_refuse;
      apb(1'b0, 8'h14, 32'h0);
      chk("unmapped error", 32'h1, er);
      chk("unmapped data", 32'h0, rd);
      frame(1'b1, 7'h05, 8'h00);
      chk("unmapped device", 32'h0, rd[15:8]);
      frame(1'b0, `CLM_ADDR_ALARMS, 8'hff);
      frame(1'b1, `CLM_ADDR_ALARMS, 8'h00);
      chk("alarms read only", 32'h0, rd[15:8]);
   endtask : t_refuse

   task automatic t_four;
      apb(1'b1, `CLM_APB_CTRL, 32'h7);
      four_pin <= 1'b1;
      frame(1'b1, `CLM_ADDR_CONTROL, 8'h00);
      chk("four-pin read", 32'h03, rd[15:8]);
   endtask : t_four

   // Counts and verdict
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : wrap_up

   // Main sequence
   initial begin
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      t_reset();
      t_setup();
      t_loss();
      mask_step(8'h0b, 1'b1);
      mask_step(8'h1b, 1'b0);
      mask_step(8'h13, 1'b1);
      t_arm();
      t_recover();
      t_refuse();
      t_four();
      wrap_up();
   end

   // Watchdog
   initial begin
      repeat (40000) @(posedge clk);
      miscompares++;
      wrap_up();
   end
endmodule : input_clock_loss_monitor_tb

`default_nettype wire
